// ==== shared/tsec_regs.svh ====
`ifndef TSEC_REGS_SVH
`define TSEC_REGS_SVH

`define TSEC_ADDR_W          12
`define TSEC_NUM_SRC         32
`define TSEC_FIELD_W         4
`define TSEC_GP_FIRST        7
`define TSEC_GP_LAST         15
`define TSEC_GP_BITS         16'hFF80

`define TSEC_OFF_LATCH       12'h000
`define TSEC_OFF_MASK        12'h004
`define TSEC_OFF_PEND        12'h008
`define TSEC_OFF_CTRL        12'h00C
`define TSEC_OFF_PMASK       12'h010
`define TSEC_OFF_PSTAT       12'h014
`define TSEC_OFF_WAKE        12'h018
`define TSEC_OFF_ASSIGN0     12'h020
`define TSEC_OFF_ASSIGN1     12'h024
`define TSEC_OFF_ASSIGN2     12'h028
`define TSEC_OFF_ASSIGN3     12'h02C

`define TSEC_CTRL_GEN_BIT    0

`define TSEC_RST_LATCH       16'h0000
`define TSEC_RST_MASK        16'h0000
`define TSEC_RST_PEND        16'h0000
`define TSEC_RST_PMASK       32'h0000_0000
`define TSEC_RST_WAKE        32'h0000_0000
`define TSEC_RST_ASSIGN0     32'h2221_1000
`define TSEC_RST_ASSIGN1     32'h4333_3332
`define TSEC_RST_ASSIGN2     32'h5555_5444
`define TSEC_RST_ASSIGN3     32'h6665_5555

`define TSEC_DETECT_CYC      2
`define TSEC_MIN_LAT_CYC     3

`endif

// ==== shared/tsec_pkg.sv ====
package tsec_pkg;

  typedef logic [15:0] tsec_evt_t;
  typedef logic [3:0]  tsec_lvl_t;
  typedef logic [31:0] tsec_word_t;

  typedef enum logic [3:0] {
    TSEC_SEL_NONE,
    TSEC_SEL_LATCH,
    TSEC_SEL_MASK,
    TSEC_SEL_PEND,
    TSEC_SEL_CTRL,
    TSEC_SEL_PMASK,
    TSEC_SEL_PSTAT,
    TSEC_SEL_WAKE,
    TSEC_SEL_ASSIGN
  } tsec_sel_t;

endpackage : tsec_pkg

// ==== rtl/tsec_event_ctrl.sv ====
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tsec_regs.svh"

module tsec_event_ctrl
  import tsec_pkg::*;
(
  input  wire logic                     mclk,
  input  wire logic                     rst_b,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`TSEC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [2:0]               pprot,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // peripheral sources, asynchronous to mclk
  input  wire logic [`TSEC_NUM_SRC-1:0] periphIrq,
  // core pipeline side
  input  wire logic                     globalEnableSet,
  input  wire logic                     globalEnableClear,
  input  wire logic                     coreIdle,
  output logic                          eventReq,
  output tsec_lvl_t                     eventLevel,
  input  wire logic                     eventAccept,
  input  wire logic                     eventReturn,
  output logic                          coreWakeup
);

  localparam tsec_evt_t GP_BITS = `TSEC_GP_BITS;

  // lowest set index wins; bit 4 flags that any bit is set
  function automatic logic [4:0] lowestSet(input tsec_evt_t v);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction : lowestSet

  // ---------------------------------------------------------------
  // source synchroniser
  // ---------------------------------------------------------------
  logic [`TSEC_NUM_SRC-1:0] srcMeta_r;
  logic [`TSEC_NUM_SRC-1:0] srcSync_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      srcMeta_r <= 32'h0000_0000;
      srcSync_r <= 32'h0000_0000;
    end else begin
      srcMeta_r <= periphIrq;
      srcSync_r <= srcMeta_r;
    end
  end

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  tsec_evt_t  latch_r;
  tsec_evt_t  latch_nxt;
  tsec_evt_t  evMask_r;
  tsec_evt_t  pend_r;
  tsec_evt_t  pend_nxt;
  tsec_evt_t  gpPrev_r;
  tsec_evt_t  gpRise_r;
  logic       glbEn_r;
  tsec_word_t pMask_r;
  tsec_word_t wakeEn_r;
  tsec_word_t assign_r [4];
  logic       wakeup_r;
  tsec_word_t prdata_r;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  tsec_sel_t  regSel;
  logic [1:0] assignIdx;
  wire logic  aligned    = (paddr[1:0] == 2'b00);
  wire logic  privileged = pprot[0];
  wire logic  setupPhase = psel & ~penable;
  wire logic  accessPh   = psel & penable;

  always_comb begin
    regSel    = TSEC_SEL_NONE;
    assignIdx = 2'b00;
    if (!aligned) begin
      regSel = TSEC_SEL_NONE;
    end else if (paddr == `TSEC_OFF_LATCH) begin
      regSel = TSEC_SEL_LATCH;
    end else if (paddr == `TSEC_OFF_MASK) begin
      regSel = TSEC_SEL_MASK;
    end else if (paddr == `TSEC_OFF_PEND) begin
      regSel = TSEC_SEL_PEND;
    end else if (paddr == `TSEC_OFF_CTRL) begin
      regSel = TSEC_SEL_CTRL;
    end else if (paddr == `TSEC_OFF_PMASK) begin
      regSel = TSEC_SEL_PMASK;
    end else if (paddr == `TSEC_OFF_PSTAT) begin
      regSel = TSEC_SEL_PSTAT;
    end else if (paddr == `TSEC_OFF_WAKE) begin
      regSel = TSEC_SEL_WAKE;
    end else if (paddr >= `TSEC_OFF_ASSIGN0 && paddr <= `TSEC_OFF_ASSIGN3) begin
      regSel    = TSEC_SEL_ASSIGN;
      assignIdx = paddr[3:2];
    end
  end

  // core registers live in supervisor-only space
  wire logic coreSel   = (regSel == TSEC_SEL_LATCH) | (regSel == TSEC_SEL_MASK) |
                         (regSel == TSEC_SEL_PEND)  | (regSel == TSEC_SEL_CTRL);
  wire logic readOnly  = (regSel == TSEC_SEL_PEND)  | (regSel == TSEC_SEL_CTRL) |
                         (regSel == TSEC_SEL_PSTAT);
  wire logic privFault = coreSel & ~privileged;
  wire logic roFault   = pwrite & readOnly;
  wire logic accErr    = (regSel == TSEC_SEL_NONE) | privFault | roFault;
  wire logic wrEn      = accessPh & pwrite & ~accErr;
  wire logic rdEn      = setupPhase & ~pwrite & ~accErr;

  wire logic wrLatch   = wrEn & (regSel == TSEC_SEL_LATCH);
  wire logic wrMask    = wrEn & (regSel == TSEC_SEL_MASK);
  wire logic wrPMask   = wrEn & (regSel == TSEC_SEL_PMASK);
  wire logic wrWake    = wrEn & (regSel == TSEC_SEL_WAKE);
  wire logic wrAssign  = wrEn & (regSel == TSEC_SEL_ASSIGN);

  assign pready  = 1'b1;
  assign pslverr = accessPh & accErr;
  assign prdata  = prdata_r;

  tsec_word_t rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (regSel)
      TSEC_SEL_LATCH:  rdMux = {16'h0000, latch_r};
      TSEC_SEL_MASK:   rdMux = {16'h0000, evMask_r};
      TSEC_SEL_PEND:   rdMux = {16'h0000, pend_r};
      TSEC_SEL_CTRL:   rdMux = {31'h0000_0000, glbEn_r};
      TSEC_SEL_PMASK:  rdMux = pMask_r;
      TSEC_SEL_PSTAT:  rdMux = srcSync_r;
      TSEC_SEL_WAKE:   rdMux = wakeEn_r;
      TSEC_SEL_ASSIGN: rdMux = assign_r[assignIdx];
      default:         rdMux = 32'h0000_0000;
    endcase
  end

  // read data is captured in the setup cycle so it stands through access
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_r <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata_r <= rdEn ? rdMux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // system stage configuration
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pMask_r  <= `TSEC_RST_PMASK;
      wakeEn_r <= `TSEC_RST_WAKE;
    end else begin
      if (wrPMask) begin
        pMask_r <= pwdata;
      end
      if (wrWake) begin
        wakeEn_r <= pwdata;
      end
    end
  end

  // default routing, overridable from software
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      assign_r[0] <= `TSEC_RST_ASSIGN0;
      assign_r[1] <= `TSEC_RST_ASSIGN1;
      assign_r[2] <= `TSEC_RST_ASSIGN2;
      assign_r[3] <= `TSEC_RST_ASSIGN3;
    end else if (wrAssign) begin
      assign_r[assignIdx] <= pwdata;
    end
  end

  logic [`TSEC_NUM_SRC*`TSEC_FIELD_W-1:0] assignFlat;
  assign assignFlat = {assign_r[3], assign_r[2], assign_r[1], assign_r[0]};

  // ---------------------------------------------------------------
  // general level inputs
  // ---------------------------------------------------------------
  wire logic [`TSEC_NUM_SRC-1:0] srcPass = srcSync_r & pMask_r;
  tsec_evt_t gpLevel;

  // field value n routes a source to level 7+n; values above 8 route nowhere
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gLevel
      if (g >= `TSEC_GP_FIRST) begin : gGen
        logic hit;
        always_comb begin
          hit = 1'b0;
          for (int i = 0; i < `TSEC_NUM_SRC; i++) begin
            if (assignFlat[i*`TSEC_FIELD_W +: `TSEC_FIELD_W] == 4'(g - `TSEC_GP_FIRST)) begin
              hit = hit | srcPass[i];
            end
          end
        end
        assign gpLevel[g] = hit;
      end else begin : gFixed
        assign gpLevel[g] = 1'b0;
      end
    end
  endgenerate

  // two-cycle edge detection on each level input
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      gpPrev_r <= 16'h0000;
      gpRise_r <= 16'h0000;
    end else begin
      gpPrev_r <= gpLevel;
      gpRise_r <= gpLevel & ~gpPrev_r;
    end
  end

  // ---------------------------------------------------------------
  // core stage: prioritisation and hand-off
  // ---------------------------------------------------------------
  wire tsec_evt_t  ready    = latch_r & evMask_r & {16{glbEn_r}} & GP_BITS;
  wire logic [4:0] reqPick  = lowestSet(ready);
  wire logic [4:0] topPend  = lowestSet(pend_r);

  // only a strictly higher priority than the active one may nest
  assign eventReq   = reqPick[4] & (~topPend[4] | (reqPick[3:0] < topPend[3:0]));
  assign eventLevel = reqPick[3:0];

  wire logic      acceptHit = eventReq & eventAccept;
  wire tsec_evt_t acceptVec = acceptHit ? (16'h0001 << reqPick[3:0]) : 16'h0000;
  wire tsec_evt_t returnVec = (eventReturn & topPend[4]) ? (16'h0001 << topPend[3:0]) :
                                                             16'h0000;

  // acceptance in the same cycle as a return still sets its bit
  assign pend_nxt = ((pend_r & ~returnVec) | acceptVec) & GP_BITS;

  // software may only touch latch bits whose mask is clear
  wire tsec_evt_t swLatchBits = wrLatch ? (~evMask_r & GP_BITS) : 16'h0000;
  wire tsec_evt_t latchSw     = (latch_r & ~swLatchBits) | (pwdata[15:0] & swLatchBits);

  // a fresh edge wins over the clear from acceptance, so it stays queued
  assign latch_nxt = ((latchSw & ~acceptVec) | gpRise_r) & GP_BITS;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latch_r <= `TSEC_RST_LATCH;
      pend_r  <= `TSEC_RST_PEND;
    end else begin
      latch_r <= latch_nxt;
      pend_r  <= pend_nxt;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      evMask_r <= `TSEC_RST_MASK;
    end else if (wrMask) begin
      evMask_r <= pwdata[15:0];
    end
  end

  // set wins if both instructions land together
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      glbEn_r <= 1'b0;
    end else if (globalEnableSet) begin
      glbEn_r <= 1'b1;
    end else if (globalEnableClear) begin
      glbEn_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // wakeup: independent of the peripheral mask so a masked source still wakes
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wakeup_r <= 1'b0;
    end else begin
      wakeup_r <= coreIdle & (|(srcSync_r & wakeEn_r));
    end
  end

  assign coreWakeup = wakeup_r;

endmodule : tsec_event_ctrl

`default_nettype wire

// ==== test/tsec_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsec_core_model (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       eventReq,
  input wire logic [3:0] accDly,
  input wire logic       doRet,
  output logic           eventAccept,
  output logic           eventReturn
);
  logic [3:0] wait_r;
  // a slow core lets the offer stand accDly+1 cycles before taking it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wait_r      <= 4'h0;
      eventAccept <= 1'b0;
      eventReturn <= 1'b0;
    end else begin
      eventReturn <= doRet;
      eventAccept <= eventReq && !eventAccept && wait_r >= accDly;
      wait_r      <= (eventReq && !eventAccept) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule : tsec_core_model
`default_nettype wire

// ==== test/tsec_event_ctrl_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsec_event_ctrl_sva
  import tsec_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [2:0]  pprot,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] periphIrq,
  input wire logic        globalEnableSet,
  input wire logic        globalEnableClear,
  input wire logic        coreIdle,
  input wire logic        eventReq,
  input wire tsec_lvl_t   eventLevel,
  input wire logic        eventAccept,
  input wire logic        eventReturn,
  input wire logic        coreWakeup
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire acc = psel && penable;
  AST_USER_CORE: assert property (acc && !pprot[0] && paddr < 12'h010 |-> pslverr)
    else $error("core register open to user");
  AST_RO_WRITE: assert property (acc && pwrite && paddr inside {12'h008, 12'h014} |-> pslverr)
    else $error("read-only write accepted");
  AST_ERR_PHASE: assert property (pslverr |-> acc)
    else $error("error outside access");
  AST_CORE_UPPER: assert property (acc && !pwrite && paddr < 12'h010 |-> prdata[31:16] == 16'h0)
    else $error("core upper bits set");
  AST_LEVEL: assert property (eventReq |-> eventLevel inside {[7:15]})
    else $error("bad level offered");
  AST_GE_OFF: assert property (globalEnableClear && !globalEnableSet |=> !eventReq)
    else $error("offer while disabled");
  AST_RST_QUIET: assert property ($rose(rst_b) |-> !eventReq && !coreWakeup)
    else $error("active after reset");
  AST_TAKEN: assert property (eventReq && eventAccept && !eventReturn |=>
    !eventReq || eventLevel < $past(eventLevel)) else $error("accepted level offered again");
  AST_IDLE_WAKE: assert property (!coreIdle |=> !coreWakeup)
    else $error("wakeup while busy");
  AST_QUIET_WAKE: assert property ((periphIrq == 32'h0)[*3] |=> !coreWakeup)
    else $error("wakeup without source");
  cover property (eventReq && eventAccept);
  cover property (coreWakeup);
  cover property (acc && pslverr);
endmodule : tsec_event_ctrl_sva
bind tsec_event_ctrl tsec_event_ctrl_sva u_sva (.*);
`default_nettype wire

// ==== test/tsec_event_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tsec_regs.svh"
module tsec_event_ctrl_tb_top;
  import tsec_pkg::*;
  logic        mclk, rst_b, psel, penable, pwrite, pready, pslverr, errv, doRet;
  logic        globalEnableSet, globalEnableClear, coreIdle, eventReq;
  logic        eventAccept, eventReturn, coreWakeup;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, periphIrq, rdv;
  logic [2:0]  pprot;
  logic [3:0]  accDly;
  tsec_lvl_t   eventLevel;
  int          n_errors, n_tests;

  tsec_event_ctrl DUT (.*);
  tsec_core_model u_core (.*);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [2:0] p);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= p;
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d, 3'h1);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0, 3'h1);
    chk(errv, 0);
    chk(rdv, e);
  endtask : rdc

  task automatic bad(input logic w, input logic [11:0] a, input logic [2:0] p);
    apb(w, a, 32'hFFFF_FFFF, p);
    chk(errv, 1);
    if (!w) chk(rdv, 0);
  endtask : bad

  task automatic ge(input logic s);
    @(posedge mclk);
    if (s) globalEnableSet <= 1;
    else globalEnableClear <= 1;
    @(posedge mclk);
    globalEnableSet <= 0;
    globalEnableClear <= 0;
  endtask : ge

  task automatic ret;
    @(posedge mclk);
    doRet <= 1;
    @(posedge mclk);
    doRet <= 0;
    // return at the edge that clears pending, so a re-offer after it is still seen
    @(posedge mclk);
  endtask : ret

  task automatic wait_acc(output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (!(eventReq === 1'b1 && eventAccept === 1'b1) && n < 60);
    chk(32'({eventReq, eventAccept}), 32'h3);
  endtask : wait_acc

  task automatic t_reset;
    logic [11:0] a [9] = '{`TSEC_OFF_LATCH, `TSEC_OFF_MASK, `TSEC_OFF_PEND, `TSEC_OFF_PMASK,
      `TSEC_OFF_WAKE, `TSEC_OFF_ASSIGN0, `TSEC_OFF_ASSIGN1, `TSEC_OFF_ASSIGN2, `TSEC_OFF_ASSIGN3};
    logic [31:0] e [9] = '{`TSEC_RST_LATCH, `TSEC_RST_MASK, `TSEC_RST_PEND, `TSEC_RST_PMASK,
      `TSEC_RST_WAKE, `TSEC_RST_ASSIGN0, `TSEC_RST_ASSIGN1, `TSEC_RST_ASSIGN2, `TSEC_RST_ASSIGN3};
    for (int i = 0; i < 9; i++) rdc(a[i], e[i]);
  endtask : t_reset

  task automatic t_priv;
    bad(1, `TSEC_OFF_MASK, 3'h0);
    bad(0, `TSEC_OFF_MASK, 3'h0);
    bad(0, `TSEC_OFF_PEND, 3'h0);
    bad(1, `TSEC_OFF_PEND, 3'h1);
    bad(1, `TSEC_OFF_PSTAT, 3'h1);
    bad(0, 12'h01C, 3'h1);
    rdc(`TSEC_OFF_MASK, 32'h0);
  endtask : t_priv

  task automatic t_event;
    int n;
    wr(`TSEC_OFF_PMASK, 32'h10);
    wr(`TSEC_OFF_MASK, 32'h100);
    ge(1);
    periphIrq[3] <= 1;
    repeat (6) @(posedge mclk);
    rdc(`TSEC_OFF_LATCH, 32'h0);
    rdc(`TSEC_OFF_PSTAT, 32'h8);
    periphIrq[4] <= 1;
    wait_acc(n);
    chk(n >= 5, 1);
    chk(32'(eventLevel), 8);
    repeat (2) @(posedge mclk);
    rdc(`TSEC_OFF_PEND, 32'h100);
    rdc(`TSEC_OFF_LATCH, 32'h0);
    periphIrq[4] <= 0;
    repeat (4) @(posedge mclk);
    periphIrq[4] <= 1;
    repeat (6) @(posedge mclk);
    rdc(`TSEC_OFF_LATCH, 32'h100);
    chk(eventReq, 0);
    ret;
    wait_acc(n);
    chk(32'(eventLevel), 8);
    periphIrq <= 0;
    ret;
    rdc(`TSEC_OFF_PEND, 32'h0);
  endtask : t_event

  task automatic t_mask;
    int n;
    wr(`TSEC_OFF_MASK, 32'h0);
    wr(`TSEC_OFF_LATCH, 32'h300);
    rdc(`TSEC_OFF_LATCH, 32'h300);
    chk(eventReq, 0);
    ge(0);
    wr(`TSEC_OFF_MASK, 32'h300);
    wr(`TSEC_OFF_LATCH, 32'h0);
    rdc(`TSEC_OFF_LATCH, 32'h300);
    chk(eventReq, 0);
    accDly <= 3;
    ge(1);
    wait_acc(n);
    chk(32'(eventLevel), 8);
    @(posedge mclk);
    chk(eventReq, 0);
    ret;
    wait_acc(n);
    chk(32'(eventLevel), 9);
    ret;
    wr(`TSEC_OFF_ASSIGN0, 32'h2221_1006);
    wr(`TSEC_OFF_PMASK, 32'h1);
    wr(`TSEC_OFF_MASK, 32'h2000);
    periphIrq[0] <= 1;
    wait_acc(n);
    chk(32'(eventLevel), 13);
    periphIrq <= 0;
    ret;
  endtask : t_mask

  task automatic t_wake;
    wr(`TSEC_OFF_WAKE, 32'h20);
    coreIdle <= 1;
    periphIrq[6] <= 1;
    repeat (5) @(posedge mclk);
    chk(coreWakeup, 0);
    periphIrq[5] <= 1;
    repeat (5) @(posedge mclk);
    chk(coreWakeup, 1);
    coreIdle <= 0;
    repeat (2) @(posedge mclk);
    chk(coreWakeup, 0);
    periphIrq <= 0;
  endtask : t_wake

  task automatic finish_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    finish_test;
  end

  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, pprot, periphIrq} = '0;
    {globalEnableSet, globalEnableClear, coreIdle, doRet, accDly} = '0;
    repeat (5) @(posedge mclk);
    rst_b <= 1;
    t_reset;
    t_priv;
    t_event;
    t_mask;
    t_wake;
    finish_test;
  end
endmodule : tsec_event_ctrl_tb_top
`default_nettype wire
